// ==== rmc_top.sv ====
// Function
// [RULE1] thirty-two relays, each independent state bit
// [RULE2] hold interval is 16-bit milliseconds
// [RULE3] short and long command spellings equal; identity answers only to the full IDN? spelling
// [RULE4] command letters matched ignoring case
// [RULE5] execute on parse; LF or END terminates
// [RULE6] commander terminates queries; others may chain
// [RULE7] close sets indexed relay 0..31
// [RULE8] index above 31 does nothing, no hold
// [RULE9] valid close/open/query holds next command
// [RULE10] interval persists until reprogrammed or reset
// [RULE11] hold after indexed reset-all, each close; a close with index above 31 does not hold
// [RULE12] identity: four fields split by semicolons
// [RULE13] query answer waits for terminator
// [RULE14] read returns last selected relay state
// [RULE15] close/open select; last one named wins
// [RULE16] status answer digit, CR, LF with END
// [RULE17] reset-all clears; indexed form also holds
// [RULE18] set-all sets; indexed form also holds
// [RULE19] delay readback decimal, CR, LF with END
// [RULE20] ready for commands within five seconds
// [RULE21] all relays open after power-up
// [RULE22] channel indicator lit while relay set
// [RULE23] hold counted on millisecond tick, stalls
`timescale 1ns/1ps
`include "rmc_map.svh"
module rmc_top #(
  parameter int N_RELAY = 32,
  parameter int MS_CYC = `RMC_MS_CYC,
  parameter int BOOT_MS = `RMC_BOOT_MS,
  parameter int IDN_LEN = 24,
  parameter logic [8*IDN_LEN-1:0] IDN_STR = "XY RM32;RELAY;V1.0;DATE0" // arbitrary value
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // command characters from the commander
  input wire logic [7:0] rx_data_i,
  input wire logic rx_end_i,
  input wire logic rx_valid_i,
  output logic rx_ready_o,
  // answer characters to the commander
  output logic [7:0] tx_data_o,
  output logic tx_end_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  // relay drivers, indicators and status
  output logic [N_RELAY-1:0] relay_o,
  output logic [N_RELAY-1:0] led_o,
  output logic ready_o
);
  localparam int IW = $clog2(N_RELAY);

  typedef struct packed {
    rmc_pkg::rmc_st_t st;
    rmc_pkg::rmc_cmd_t cmd;
    rmc_pkg::rmc_rsp_t rkind;
    logic have;
    logic [7:0] ch;
    logic chend;
    logic pterm;
    logic rxr;
    logic [2:0] kidx;
    logic [16:0] num;
    logic [2:0] ndig;
    logic ovf;
    logic [N_RELAY-1:0] relay;
    logic [IW-1:0] sel;
    logic [15:0] dly;
    logic [15:0] hold;
    logic [31:0] div;
    logic [31:0] boot;
    logic rdy;
    logic [7:0] ridx;
    logic [19:0] bcd;
    logic b0_v;
    logic [7:0] b0_d;
    logic b0_e;
    logic b1_v;
    logic [7:0] b1_d;
    logic b1_e;
  } rmc_state_t;

  rmc_state_t s_r;
  rmc_state_t s_nxt;
  logic fin_c;
  logic idx_ok_c;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // fold lower case onto upper case
  function automatic logic [7:0] to_upper(input logic [7:0] c);
    logic [7:0] u;
    u = c;
    if (c >= `RMC_CH_LA && c <= `RMC_CH_LZ) begin
      u = c - `RMC_CASE;
    end
    return u;
  endfunction

  // character of the long spelling at a position
  function automatic logic [7:0] kw_char(input rmc_pkg::rmc_cmd_t c, input logic [2:0] i);
    logic [47:0] w;
    w = '0;
    unique case (c)
      rmc_pkg::CM_DLY: w = `RMC_KW_DLY;
      rmc_pkg::CM_RST: w = `RMC_KW_RST;
      rmc_pkg::CM_SET: w = `RMC_KW_SET;
      rmc_pkg::CM_CLS: w = `RMC_KW_CLS;
      rmc_pkg::CM_OPN: w = `RMC_KW_OPN;
      rmc_pkg::CM_QRY: w = `RMC_KW_QRY;
      rmc_pkg::CM_TIM: w = `RMC_KW_TIM;
      rmc_pkg::CM_IDN: w = `RMC_KW_IDN;
    endcase
    if (i >= 3'(`RMC_KW_LEN)) begin
      return 8'h00;
    end
    return w[47 - 8*i -: 8];
  endfunction

  // binary to five decimal digits
  function automatic logic [19:0] to_bcd(input logic [15:0] v);
    logic [35:0] t;
    t = {20'h00000, v};
    for (int i = 0; i < 16; i++) begin
      for (int d = 0; d < 5; d++) begin
        if (t[16 + 4*d +: 4] >= 4'h5) begin
          t[16 + 4*d +: 4] = t[16 + 4*d +: 4] + 4'h3;
        end
      end
      t = t << 1;
    end
    return t[35:16];
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic tick;
    logic term;
    logic consume;
    logic hld;
    logic gen_v;
    logic gen_last;
    logic [7:0] gen_d;
    logic [20:0] acc;
    logic [7:0] c;
    s_nxt = s_r;
    tick = 1'b0;
    term = 1'b0;
    consume = 1'b0;
    hld = 1'b0;
    gen_v = 1'b0;
    gen_last = 1'b0;
    gen_d = 8'h00;
    acc = '0;
    c = s_r.ch;
    fin_c = 1'b0;
    // millisecond divider
    if (s_r.div >= 32'(MS_CYC - 1)) begin
      s_nxt.div = '0;
      tick = 1'b1;
    end else begin
      s_nxt.div = s_r.div + 32'h1;
    end
    // one-character input latch, case folded
    if (rx_valid_i && s_r.rxr) begin
      s_nxt.have = 1'b1;
      s_nxt.ch = to_upper(rx_data_i); // [RULE4]
      s_nxt.chend = rx_end_i;
    end
    term = (s_r.have && c == `RMC_CH_LF) || (s_r.pterm && !s_r.have); // [RULE5]
    idx_ok_c = s_r.ndig != 3'h0 && !s_r.ovf && s_r.num < 17'(N_RELAY);
    unique case (s_r.st)
      rmc_pkg::ST_BOOT: begin
        if (tick) begin
          s_nxt.boot = s_r.boot + 32'h1;
        end
        if (s_r.boot >= 32'(BOOT_MS - 1)) begin
          s_nxt.rdy = 1'b1; // [RULE20]
          s_nxt.st = rmc_pkg::ST_CMD;
        end
      end
      rmc_pkg::ST_CMD: begin
        if (term) begin
          consume = s_r.have;
          s_nxt.pterm = 1'b0;
          if (s_r.rkind != rmc_pkg::RS_NONE) begin
            s_nxt.st = rmc_pkg::ST_RESP; // [RULE13]
          end
          s_nxt.bcd = to_bcd(s_r.dly);
          s_nxt.ridx = 8'h4;
          if (s_r.rkind == rmc_pkg::RS_IDN) begin
            s_nxt.ridx = 8'h0;
          end else if (s_r.rkind == rmc_pkg::RS_TIME) begin
            // skip leading zeros, keep the last digit
            for (int i = 3; i >= 0; i--) begin
              if (s_nxt.bcd[19 - 4*i -: 4] != 4'h0) begin
                s_nxt.ridx = 8'(i);
              end
            end
          end
        end else if (s_r.have) begin
          consume = 1'b1;
          s_nxt.kidx = 3'h1;
          s_nxt.num = '0;
          s_nxt.ndig = 3'h0;
          s_nxt.ovf = 1'b0;
          s_nxt.st = rmc_pkg::ST_NAME;
          // first letter picks the command; others are ignored
          unique case (c)
            "D": s_nxt.cmd = rmc_pkg::CM_DLY;
            "R": s_nxt.cmd = rmc_pkg::CM_RST;
            "S": s_nxt.cmd = rmc_pkg::CM_SET;
            "C": s_nxt.cmd = rmc_pkg::CM_CLS;
            "O": s_nxt.cmd = rmc_pkg::CM_OPN;
            "Q": s_nxt.cmd = rmc_pkg::CM_QRY;
            "T": s_nxt.cmd = rmc_pkg::CM_TIM;
            "I": s_nxt.cmd = rmc_pkg::CM_IDN;
            default: s_nxt.st = rmc_pkg::ST_CMD;
          endcase
        end
      end
      rmc_pkg::ST_NAME, rmc_pkg::ST_NUM: begin
        if (s_r.have && c >= `RMC_CH_0 && c <= `RMC_CH_9 && s_r.cmd != rmc_pkg::CM_IDN) begin
          consume = 1'b1;
          s_nxt.st = rmc_pkg::ST_NUM;
          acc = {4'h0, s_r.num} * 21'd10 + {13'h0, c - `RMC_CH_0};
          if (s_r.ndig != 3'h7) begin
            s_nxt.ndig = s_r.ndig + 3'h1;
          end
          if (acc > 21'(`RMC_DLY_MAX)) begin
            s_nxt.ovf = 1'b1;
          end else begin
            s_nxt.num = acc[16:0];
          end
        end else if (s_r.have && s_r.st == rmc_pkg::ST_NAME && c == kw_char(s_r.cmd, s_r.kidx)) begin
          consume = 1'b1; // long spelling letter [RULE3]
          s_nxt.kidx = s_r.kidx + 3'h1;
        end else if (s_r.have || s_r.pterm) begin
          fin_c = 1'b1; // char is kept for the next command
        end
      end
      rmc_pkg::ST_HOLD: begin
        if (tick && s_r.hold != 16'h0) begin
          s_nxt.hold = s_r.hold - 16'h1; // [RULE23]
        end
        if (s_r.hold == 16'h0) begin
          s_nxt.st = rmc_pkg::ST_CMD;
        end
      end
      rmc_pkg::ST_RESP: begin
        if (!s_r.b1_v) begin
          gen_v = 1'b1;
          if (s_r.rkind == rmc_pkg::RS_IDN) begin
            gen_last = s_r.ridx == 8'(IDN_LEN + 1);
            gen_d = s_r.ridx < 8'(IDN_LEN) ? IDN_STR[8*IDN_LEN - 1 - 8*s_r.ridx -: 8] :
                    (gen_last ? `RMC_CH_LF : `RMC_CH_CR); // [RULE12]
          end else begin
            gen_last = s_r.ridx == 8'h6;
            if (s_r.ridx == 8'h5) begin
              gen_d = `RMC_CH_CR;
            end else if (gen_last) begin
              gen_d = `RMC_CH_LF; // [RULE16]
            end else if (s_r.rkind == rmc_pkg::RS_STAT) begin
              gen_d = `RMC_CH_0 + {7'h00, s_r.relay[s_r.sel]}; // [RULE14]
            end else begin
              gen_d = `RMC_CH_0 + {4'h0, s_r.bcd[19 - 4*s_r.ridx[2:0] -: 4]}; // [RULE19]
            end
          end
          s_nxt.ridx = s_r.ridx + 8'h1;
          if (gen_last) begin
            s_nxt.rkind = rmc_pkg::RS_NONE;
            s_nxt.st = rmc_pkg::ST_CMD;
          end
        end
      end
    endcase
    // execute a parsed command at once
    if (fin_c) begin
      s_nxt.st = rmc_pkg::ST_CMD;
      unique case (s_r.cmd)
        rmc_pkg::CM_DLY: begin
          if (s_r.ndig != 3'h0 && !s_r.ovf) begin
            s_nxt.dly = s_r.num[15:0]; // [RULE2] [RULE10]
          end
        end
        rmc_pkg::CM_RST: begin
          s_nxt.relay = '0; // [RULE17] [RULE22]
          hld = idx_ok_c; // [RULE11]
        end
        rmc_pkg::CM_SET: begin
          s_nxt.relay = '1; // [RULE18]
          hld = idx_ok_c;
        end
        rmc_pkg::CM_CLS, rmc_pkg::CM_OPN, rmc_pkg::CM_QRY: begin
          if (s_r.cmd == rmc_pkg::CM_QRY) begin
            s_nxt.rkind = rmc_pkg::RS_STAT;
          end
          if (idx_ok_c) begin // [RULE8]
            hld = 1'b1; // [RULE9]
            s_nxt.sel = s_r.num[IW-1:0]; // [RULE15]
            if (s_r.cmd == rmc_pkg::CM_CLS) begin
              s_nxt.relay[s_r.num[IW-1:0]] = 1'b1; // [RULE7] [RULE1]
            end else if (s_r.cmd == rmc_pkg::CM_OPN) begin
              s_nxt.relay[s_r.num[IW-1:0]] = 1'b0;
            end
          end
        end
        rmc_pkg::CM_TIM: s_nxt.rkind = rmc_pkg::RS_TIME;
        rmc_pkg::CM_IDN: begin
          if (s_r.kidx == 3'(`RMC_IDN_LEN)) begin
            s_nxt.rkind = rmc_pkg::RS_IDN;
          end
        end
      endcase
      if (hld) begin
        s_nxt.st = rmc_pkg::ST_HOLD;
        s_nxt.hold = s_r.dly;
        s_nxt.div = '0; // full first millisecond
      end
    end
    if (consume) begin
      s_nxt.have = 1'b0;
      s_nxt.pterm = s_r.pterm | s_r.chend;
    end
    // two-entry answer buffer
    if (s_r.b0_v && tx_ready_i) begin
      s_nxt.b0_v = s_r.b1_v;
      s_nxt.b0_d = s_r.b1_d;
      s_nxt.b0_e = s_r.b1_e;
      s_nxt.b1_v = 1'b0;
    end
    if (gen_v) begin
      if (!s_nxt.b0_v) begin
        s_nxt.b0_v = 1'b1;
        s_nxt.b0_d = gen_d;
        s_nxt.b0_e = gen_last;
      end else begin
        s_nxt.b1_v = 1'b1;
        s_nxt.b1_d = gen_d;
        s_nxt.b1_e = gen_last;
      end
    end
    s_nxt.rxr = !s_nxt.have;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r <= '0; // relays open, interval zero [RULE21]
      s_r.st <= rmc_pkg::ST_BOOT;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign rx_ready_o = s_r.rxr;
  assign tx_valid_o = s_r.b0_v;
  assign tx_data_o = s_r.b0_d;
  assign tx_end_o = s_r.b0_e;
  assign relay_o = s_r.relay;
  assign led_o = s_r.relay; // [RULE22]
  assign ready_o = s_r.rdy;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_hold_stall: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE23]
    s_r.st == rmc_pkg::ST_HOLD && s_r.hold != 16'h0 |=> $stable(s_r.relay))
    else $error("relays changed during hold");
  chk_close_sets: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE7]
    fin_c && s_r.cmd == rmc_pkg::CM_CLS && idx_ok_c |=> relay_o[$past(s_r.num[IW-1:0])] &&
    led_o[s_r.sel] && s_r.sel == $past(s_r.num[IW-1:0]))
    else $error("close did not set relay");
  chk_bad_index: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE8]
    fin_c && s_r.cmd inside {rmc_pkg::CM_CLS, rmc_pkg::CM_OPN} && !idx_ok_c
    |=> $stable(relay_o) && s_r.st != rmc_pkg::ST_HOLD)
    else $error("bad index acted");
  chk_reset_all: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE17]
    fin_c && s_r.cmd == rmc_pkg::CM_RST |=> relay_o == '0 && led_o == '0)
    else $error("reset-all left relay set");
  chk_set_all: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE18]
    fin_c && s_r.cmd == rmc_pkg::CM_SET && idx_ok_c |=> &relay_o && s_r.hold == s_r.dly)
    else $error("set-all failed");
  chk_end_on_lf: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE16]
    tx_valid_o && tx_end_o |-> tx_data_o == `RMC_CH_LF)
    else $error("end flag not on line feed");
  chk_hold_load: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE9]
    fin_c && s_r.cmd == rmc_pkg::CM_OPN && idx_ok_c |=> s_r.hold == $past(s_r.dly) ##0
    s_r.st == rmc_pkg::ST_HOLD)
    else $error("hold not loaded");
  chk_boot_open: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE21]
    !ready_o |-> relay_o == '0 && led_o == '0 && !tx_valid_o)
    else $error("relay set before ready");
  chk_dly_prog: assert property (@(posedge mclk_i) disable iff (!arst_n_i) // [RULE2]
    fin_c && s_r.cmd == rmc_pkg::CM_DLY && s_r.ndig != 3'h0 && !s_r.ovf
    |=> s_r.dly == $past(s_r.num[15:0]))
    else $error("delay not programmed");
endmodule

// ==== rmc_map.svh ====
`ifndef RMC_MAP_SVH
`define RMC_MAP_SVH
// ----------------------------------------
// clock and timing
// ----------------------------------------
`define RMC_CLK_HZ 40000000
`define RMC_TICK_MS 1
`define RMC_MS_CYC ((`RMC_CLK_HZ / 1000) * `RMC_TICK_MS)
`define RMC_BOOT_S 5
`define RMC_BOOT_MS (`RMC_BOOT_S * 1000)
`define RMC_DLY_MAX 65535
// ----------------------------------------
// characters
// ----------------------------------------
`define RMC_CH_CR 8'h0d
`define RMC_CH_LF 8'h0a
`define RMC_CH_0 8'h30
`define RMC_CH_9 8'h39
`define RMC_CH_LA 8'h61
`define RMC_CH_LZ 8'h7a
`define RMC_CASE 8'h20
// ----------------------------------------
// keywords, left aligned in six characters
// ----------------------------------------
`define RMC_KW_DLY {"DELAY", 8'h00}
`define RMC_KW_RST {"RESET", 8'h00}
`define RMC_KW_SET {"SET", 24'h000000}
`define RMC_KW_CLS {"CLOSE", 8'h00}
`define RMC_KW_OPN {"OPEN", 16'h0000}
`define RMC_KW_QRY "QUERY?"
`define RMC_KW_TIM {"TIME?", 8'h00}
`define RMC_KW_IDN {"IDN?", 16'h0000}
`define RMC_KW_LEN 6
`define RMC_IDN_LEN 4
`endif

// ==== rmc_pkg.sv ====
package rmc_pkg;
  typedef enum logic [2:0] {ST_BOOT, ST_CMD, ST_NAME, ST_NUM, ST_HOLD, ST_RESP} rmc_st_t;
  typedef enum logic [2:0] {CM_DLY, CM_RST, CM_SET, CM_CLS, CM_OPN, CM_QRY, CM_TIM,
                            CM_IDN} rmc_cmd_t;
  typedef enum logic [1:0] {RS_NONE, RS_STAT, RS_TIME, RS_IDN} rmc_rsp_t;
endpackage

// ==== rmc_host.sv ====
`timescale 1ns/1ps
module rmc_host (
  // clock and reset
  input wire logic mclk_i,
  input wire logic arst_n_i,
  // command characters to the device
  output logic [7:0] rx_data_o,
  output logic rx_end_o,
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  // answer characters from the device
  input wire logic [7:0] tx_data_i,
  input wire logic tx_end_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o
);
  int seed = 32'h0b16;
  int n_timeout = 0;
  logic [8:0] rxq[$];

  // idle lines before the first frame
  initial begin
    rx_data_o = 8'h00;
    rx_end_o = 1'b0;
    rx_valid_o = 1'b0;
  end

  // collect answer beats, stalling about one cycle in four
  always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_ready_o <= 1'b0;
    end else begin
      if (tx_valid_i && tx_ready_o) rxq.push_back({tx_end_i, tx_data_i});
      tx_ready_o <= (($random(seed) & 3) != 0);
    end
  end

  // offer each character and hold it until taken; end flag rides the last one
  task automatic send(input string s, input bit use_end);
    int n;
    @(posedge mclk_i);
    for (int i = 0; i < s.len(); i++) begin
      rx_data_o <= s[i];
      rx_end_o <= use_end && (i == s.len() - 1);
      rx_valid_o <= 1'b1;
      n = 0;
      do begin
        @(posedge mclk_i);
        n++;
      end while (!rx_ready_i && n < 4000);
      if (!rx_ready_i) n_timeout++;
    end
    // released data line shows the inverse, not the last value
    rx_valid_o <= 1'b0;
    rx_end_o <= 1'b0;
    rx_data_o <= ~rx_data_o;
  endtask
endmodule

// ==== relay_matrix_ascii_commander_test.sv ====
`timescale 1ns/1ps
module relay_matrix_ascii_commander_test;
  // ----------------------------------------
  // clock, reset and wiring
  // ----------------------------------------
  localparam int MS = 4;
  localparam int BOOT = 3;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] rx_data, tx_data;
  logic rx_end, rx_valid, rx_ready, tx_end, tx_valid, tx_ready, ready;
  logic [31:0] relay, led, model;
  int seed = 32'h0b16;
  int miscompares = 0;
  int n_compared = 0;

  // module clock, 25 ns period
  always #12.5 mclk_i = ~mclk_i;

  rmc_top #(.MS_CYC(MS), .BOOT_MS(BOOT)) DUT (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .rx_data_i(rx_data), .rx_end_i(rx_end), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
    .tx_data_o(tx_data), .tx_end_o(tx_end), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
    .relay_o(relay), .led_o(led), .ready_o(ready)
  );

  rmc_host host (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .rx_data_o(rx_data), .rx_end_o(rx_end), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
    .tx_data_i(tx_data), .tx_end_i(tx_end), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready)
  );

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    miscompares += host.n_timeout;
    $display("comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // a wait that used its whole bound ends the run
  task automatic bail(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      final_report();
    end
  endtask

  // a stuck character offer ends the run at once
  always @(negedge mclk_i) begin
    if (host.n_timeout != 0) begin
      final_report();
    end
  end

  // expected status answer: digit, CR, LF
  function automatic string exp_stat(input logic v);
    return v ? string'("1\015\n") : string'("0\015\n");
  endfunction

  // expected delay answer: decimal without leading zeros, CR, LF
  function automatic string exp_time(input int v);
    return $sformatf("%0d\015\n", v);
  endfunction

  // ready comes after all but the last millisecond of the boot wait, no later than its full length
  task automatic wait_ready;
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 100) begin
      @(negedge mclk_i);
      n++;
    end
    bail(n, 100);
    chk(n > (BOOT - 1) * MS && n <= BOOT * MS + 2, 1);
  endtask

  // relays settle to the expected pattern; indicators follow them
  task automatic wait_relays(input logic [31:0] exp);
    int n;
    n = 0;
    while (relay !== exp && n < 3000) begin
      @(negedge mclk_i);
      n++;
    end
    bail(n, 3000);
    chk(relay, exp);
    chk(led, exp);
  endtask

  // gather one answer up to its end-flagged beat
  task automatic get_resp(output string s);
    int n;
    n = 0;
    s = "";
    while (!(host.rxq.size() > 0 && host.rxq[$][8]) && n < 4000) begin
      @(negedge mclk_i);
      n++;
    end
    bail(n, 4000);
    chk(n < 4000, 1);
    foreach (host.rxq[i]) begin
      s = {s, $sformatf("%c", host.rxq[i][7:0])};
      chk(host.rxq[i][8], i == host.rxq.size() - 1);
    end
    host.rxq.delete();
  endtask

  task automatic query(input string cmd, input string exp);
    string r;
    host.send(cmd, 1'b0);
    get_resp(r);
    chk(r == exp, 1);
  endtask

  // cycles from relay a reaching va to relay b reaching vb span a full hold
  task automatic gap_of(input string cmd, input int a, input logic va, input int b,
                        input logic vb);
    int n;
    int g;
    n = 0;
    g = 0;
    fork
      host.send(cmd, 1'b0);
      begin
        while (relay[a] !== va && n < 4000) begin
          @(negedge mclk_i);
          n++;
        end
        bail(n, 4000);
        while (relay[b] !== vb && g < 4000) begin
          @(negedge mclk_i);
          g++;
        end
        bail(g, 4000);
      end
    join
    // parsing alone takes under 10 cycles; the 2 ms hold adds 2 * MS
    chk(g >= 2 * MS + 2 && g < 2 * MS + 40, 1);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    string r;
    string cmd;
    int idx;
    int sc;
    int d;
    logic [31:0] rnd;
    logic op;
    logic lg;
    model = '0;
    repeat (8) @(posedge mclk_i);
    chk(relay, 0);
    arst_n_i <= 1'b1;
    wait_ready();
    host.send("Q03", 1'b0);
    repeat (40) @(negedge mclk_i);
    chk(host.rxq.size(), 0);
    host.send("\015\n", 1'b0);
    get_resp(r);
    chk(r == exp_stat(1'b0), 1);
    host.send("C05\n", 1'b0);
    model[5] = 1'b1;
    wait_relays(model);
    host.send("cLoSe7\n", 1'b0);
    model[7] = 1'b1;
    wait_relays(model);
    host.send("open05\n", 1'b0);
    model[5] = 1'b0;
    wait_relays(model);
    host.send("C09", 1'b1);
    model[9] = 1'b1;
    wait_relays(model);
    host.send("C32O07\n", 1'b0);
    model[7] = 1'b0;
    wait_relays(model);
    host.send("O03C09\n", 1'b0);
    query("q40\n", exp_stat(1'b1));
    query("QUERY?03\n", exp_stat(1'b0));
    host.send("SET\n", 1'b0);
    wait_relays('1);
    host.send("r00\n", 1'b0);
    wait_relays('0);
    host.send("D2\n", 1'b0);
    gap_of("c01c02\n", 1, 1'b1, 2, 1'b1);
    gap_of("R00C06\n", 1, 1'b0, 6, 1'b1);
    gap_of("S00r\n", 0, 1'b1, 0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      rnd = $random(seed);
      d = (k == 0) ? 65535 : int'(rnd[15:0]);
      host.send($sformatf("DELAY%0d\n", d), 1'b0);
      query(k[0] ? string'("T\n") : string'("time?\n"), exp_time(d));
    end
    host.send("d70000\n", 1'b0);
    query("T\n", exp_time(d));
    host.send("D0\n", 1'b0);
    host.send("IDN?\n", 1'b0);
    get_resp(r);
    sc = 0;
    for (int i = 0; i < r.len(); i++) begin
      if (r[i] == ";") begin
        sc++;
      end
    end
    chk(sc, 3);
    chk(r.len(), 26);
    model = '0;
    for (int k = 0; k < 20; k++) begin
      rnd = $random(seed);
      idx = int'(rnd[4:0]);
      op = rnd[8];
      lg = rnd[9];
      cmd = op ? (lg ? string'("Close") : string'("c")) : (lg ? string'("OPEN") : string'("o"));
      host.send($sformatf("%s%02d\n", cmd, idx), 1'b0);
      model[idx] = op;
      wait_relays(model);
      query($sformatf("q%0d\n", idx), exp_stat(op));
    end
    host.send("D5C03\n", 1'b0);
    @(posedge mclk_i);
    arst_n_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    chk(relay, 0);
    arst_n_i <= 1'b1;
    wait_ready();
    query("T\n", exp_time(0));
    final_report();
  end
endmodule
